// ===== design/upio_pkg.sv
// Constants and types for the upper I/O port with change interrupt
package upio_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT    = 8'h06;
  localparam logic [7:0] IDX_OPTION  = 8'h81;
  localparam logic [7:0] IDX_DIR     = 8'h86;
  localparam logic [7:0] IDX_CORE_INTERRUPT_CONTROL  = 8'h8b;
  localparam logic [7:0] IDX_IRQ_STS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h91;
  localparam int         ADDR_W      = 12;
  // Option register fields
  localparam int OPT_PULLUP_DIS_N = 7;
  localparam int OPT_EDGE_SEL     = 6;
  // Control register fields
  localparam int IC_CHG_FLAG  = 0;
  localparam int IC_EXT_FLAG  = 1;
  localparam int IC_CHG_EN    = 3;
  localparam int IC_EXT_EN    = 4;
  localparam int IC_GLOBAL_EN = 7;
  // Sticky status bit positions
  localparam int ST_CHG = 0;
  localparam int ST_EXT = 1;
  // Values after reset
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_DIR    = 8'hff;
  localparam logic [7:0] RST_CORE_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_LATCH  = 8'h00;
  localparam logic [1:0] RST_IRQ    = 2'h0;
  // Decoded register selection
  typedef enum logic [2:0] {
    SEL_NONE, SEL_PORT, SEL_OPTION, SEL_DIR,
    SEL_CORE_INTERRUPT_CONTROL, SEL_STS, SEL_MSK
  } reg_sel_t;
endpackage : upio_pkg

// ===== design/upper_io_port_change_int.sv
// Upper I/O port: pins, pull-ups, change and edge interrupts, APB regs
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module upper_io_port_change_int
  import upio_pkg::*;
(
  input  wire logic              sys_clk,     // 40 MHz core clock
  input  wire logic              rst,         // Sync reset, high
  input  wire logic              ce,          // Low freezes all state
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB access phase
  input  wire logic              pwrite,      // APB direction
  input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // Unmapped access
  input  wire logic [7:0]        pin_in,      // Pin levels
  output logic      [7:0]        pin_out,     // Driven levels
  output logic      [7:0]        pin_oe_n,    // Low while driving
  output logic      [7:0]        pullup_en,   // Weak pull-up on
  input  wire logic              sleep_mode,  // Core is asleep
  output logic                   wake_req,    // Wake the core
  output logic                   core_irq,    // Core interrupt
  output logic                   irq          // Masked status irq
);

  // Whole block state in one record
  typedef struct packed {
    logic [7:0]  out_latch;  // Output data latch
    logic [7:0]  dir;        // One = input
    logic [7:0]  option;     // Pull-up and edge control
    logic [7:0]  core_interrupt_control;     // Flags and enables
    logic [3:0]  ref_val;    // Reference of pins 7..4
    logic        pin0_prev;  // Last sample of pin 0
    logic [1:0]  irq_sts;    // Sticky event bits
    logic [1:0]  irq_msk;    // Mask of the same layout
    logic [31:0] prdata;     // Read data, loaded at setup
  } state_t;

  state_t st_ff;   // Registered state
  state_t nxt_st;  // Next state

  // Address to register selection, used by read and write paths
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    // Only aligned words are mapped
    if (a[1:0] == 2'h0)
    begin
      case (a[ADDR_W-1:2])
        10'(IDX_PORT):    s = SEL_PORT;
        10'(IDX_OPTION):  s = SEL_OPTION;
        10'(IDX_DIR):     s = SEL_DIR;
        10'(IDX_CORE_INTERRUPT_CONTROL):  s = SEL_CORE_INTERRUPT_CONTROL;
        10'(IDX_IRQ_STS): s = SEL_STS;
        10'(IDX_IRQ_MSK): s = SEL_MSK;
        default:          s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  reg_sel_t   sel;       // Current decode
  logic       setup;     // APB setup cycle
  logic       acc;       // APB access cycle
  logic       wr;        // Write takes effect
  logic       rd;        // Read completes
  logic       port_acc;  // Any port read or write
  logic [3:0] mismatch;  // Per-pin change compare
  logic       chg;       // Any change mismatch
  logic       ext_edge;  // Selected edge on pin 0

  // Bus phase decode
  always_comb
  begin
    sel      = decode(paddr);
    setup    = psel && !penable;
    acc      = psel && penable;
    wr       = acc && pwrite && (sel != SEL_NONE);
    rd       = acc && !pwrite && (sel != SEL_NONE);
    port_acc = (wr || rd) && (sel == SEL_PORT);
  end

  // Event detection
  always_comb
  begin
    // Output pins drop out of the compare
    mismatch = (pin_in[7:4] ^ st_ff.ref_val) & st_ff.dir[7:4];
    chg      = |mismatch;
    // Edge polarity chosen by option bit 6
    if (st_ff.option[OPT_EDGE_SEL])
      ext_edge = pin_in[0] && !st_ff.pin0_prev;
    else
      ext_edge = !pin_in[0] && st_ff.pin0_prev;
  end

  // Next state: software effects first, hardware sets last
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pin0_prev = pin_in[0];
    // Read data is captured in setup so it comes from a flop
    if (setup)
    begin
      case (sel)
        SEL_PORT:   nxt_st.prdata = {24'h0, pin_in};
        SEL_OPTION: nxt_st.prdata = {24'h0, st_ff.option};
        SEL_DIR:    nxt_st.prdata = {24'h0, st_ff.dir};
        SEL_CORE_INTERRUPT_CONTROL: nxt_st.prdata = {24'h0, st_ff.core_interrupt_control};
        SEL_STS:    nxt_st.prdata = {30'h0, st_ff.irq_sts};
        SEL_MSK:    nxt_st.prdata = {30'h0, st_ff.irq_msk};
        default:    nxt_st.prdata = 32'h0;
      endcase
    end
    // Register writes
    if (wr)
    begin
      case (sel)
        SEL_PORT:   nxt_st.out_latch = pwdata[7:0];
        SEL_OPTION: nxt_st.option    = pwdata[7:0];
        SEL_DIR:    nxt_st.dir       = pwdata[7:0];
        SEL_CORE_INTERRUPT_CONTROL: nxt_st.core_interrupt_control    = pwdata[7:0];
        SEL_MSK:    nxt_st.irq_msk   = pwdata[1:0];
        default:    nxt_st.irq_msk   = nxt_st.irq_msk;
      endcase
    end
    // Port read or write relatches the reference
    if (port_acc)
      nxt_st.ref_val = pin_in[7:4];
    // Status clears on read, but only the bits that the read returned,
    // so an event landing in the setup cycle is not lost
    if (rd && (sel == SEL_STS))
      nxt_st.irq_sts = st_ff.irq_sts & ~st_ff.prdata[1:0];
    // Set wins over a same-cycle clear; mismatch re-sets each cycle
    if (chg)
    begin
      nxt_st.core_interrupt_control[IC_CHG_FLAG] = 1'b1;
      nxt_st.irq_sts[ST_CHG]     = 1'b1;
    end
    if (ext_edge)
    begin
      nxt_st.core_interrupt_control[IC_EXT_FLAG] = 1'b1;
      nxt_st.irq_sts[ST_EXT]     = 1'b1;
    end
  end

  // State register; reset wins over the clock enable
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff.out_latch <= RST_LATCH;
      st_ff.dir       <= RST_DIR;
      st_ff.option    <= RST_OPTION;
      st_ff.core_interrupt_control    <= RST_CORE_INTERRUPT_CONTROL;
      st_ff.ref_val   <= 4'h0;
      st_ff.pin0_prev <= 1'b0;
      st_ff.irq_sts   <= RST_IRQ;
      st_ff.irq_msk   <= RST_IRQ;
      st_ff.prdata    <= 32'h0;
    end
    else if (ce)
      st_ff <= nxt_st;
  end

  // Pin drivers and pull-ups
  always_comb
  begin
    pin_oe_n = st_ff.dir;       // One floats the pin
    pin_out  = st_ff.out_latch; // Latch drives output pins
    // Global enable, then forced off on outputs
    pullup_en = {8{~st_ff.option[OPT_PULLUP_DIS_N]}} & st_ff.dir;
  end

  // Interrupt and wake outputs
  always_comb
  begin
    core_irq = st_ff.core_interrupt_control[IC_GLOBAL_EN] &&
      ((st_ff.core_interrupt_control[IC_CHG_FLAG] && st_ff.core_interrupt_control[IC_CHG_EN]) ||
       (st_ff.core_interrupt_control[IC_EXT_FLAG] && st_ff.core_interrupt_control[IC_EXT_EN]));
    // Wake ignores the global enable so a key press ends sleep
    wake_req = sleep_mode && st_ff.core_interrupt_control[IC_CHG_EN] &&
      st_ff.core_interrupt_control[IC_CHG_FLAG];
    irq = |(st_ff.irq_sts & st_ff.irq_msk);
  end

  // Zero wait states; unmapped words answer with an error
  always_comb
  begin
    pready  = 1'b1;
    pslverr = acc && (sel == SEL_NONE);
    prdata  = st_ff.prdata;
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_dir_float;
    st_ff.dir == pin_oe_n;
  endproperty
  a_dir_float: assert property (p_dir_float)
    else $error("pin enable does not follow direction");

  property p_drive_latch;
    ce && wr && sel == SEL_PORT ##1 1'b1 |-> pin_out == $past(pwdata[7:0]);
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("port write did not reach pins");

  property p_pullup_gate;
    (pullup_en & ~st_ff.dir) == 8'h00 &&
    (!st_ff.option[OPT_PULLUP_DIS_N] || pullup_en == 8'h00);
  endproperty
  a_pullup_gate: assert property (p_pullup_gate)
    else $error("pull-up on output or while disabled");

  property p_pullup_on;
    !st_ff.option[OPT_PULLUP_DIS_N] |-> pullup_en == st_ff.dir;
  endproperty
  a_pullup_on: assert property (p_pullup_on)
    else $error("pull-ups not enabled together");

  property p_reset_vals;
    $past(rst) |-> st_ff.option == RST_OPTION && pullup_en == 8'h00 &&
      st_ff.core_interrupt_control == RST_CORE_INTERRUPT_CONTROL;
  endproperty
  a_reset_vals: assert property (@(posedge sys_clk) p_reset_vals)
    else $error("wrong values after reset");

  property p_chg_sets;
    ce && (|((pin_in[7:4] ^ st_ff.ref_val) & st_ff.dir[7:4]))
      |=> st_ff.core_interrupt_control[IC_CHG_FLAG];
  endproperty
  a_chg_sets: assert property (p_chg_sets)
    else $error("mismatch did not set change flag");

  property p_out_excluded;
    ce && st_ff.dir[7:4] == 4'h0 && !st_ff.core_interrupt_control[IC_CHG_FLAG] &&
      !(wr && sel == SEL_CORE_INTERRUPT_CONTROL) |=> !st_ff.core_interrupt_control[IC_CHG_FLAG];
  endproperty
  a_out_excluded: assert property (p_out_excluded)
    else $error("output pins raised change flag");

  property p_ref_latch;
    ce && port_acc |=> st_ff.ref_val == $past(pin_in[7:4]);
  endproperty
  a_ref_latch: assert property (p_ref_latch)
    else $error("reference not refreshed on port access");

  property p_persist;
    ce && chg && wr && sel == SEL_CORE_INTERRUPT_CONTROL && !pwdata[IC_CHG_FLAG]
      |=> st_ff.core_interrupt_control[IC_CHG_FLAG];
  endproperty
  a_persist: assert property (p_persist)
    else $error("clear beat an ongoing mismatch");

  property p_edge;
    ce ##1 ce && (st_ff.option[OPT_EDGE_SEL] ?
      ($rose(pin_in[0])) : ($fell(pin_in[0])))
      |=> st_ff.core_interrupt_control[IC_EXT_FLAG];
  endproperty
  a_edge: assert property (p_edge)
    else $error("selected edge missed");

  property p_core_irq;
    core_irq |-> st_ff.core_interrupt_control[IC_GLOBAL_EN];
  endproperty
  a_core_irq: assert property (p_core_irq)
    else $error("core request without global enable");

  property p_wake;
    sleep_mode && chg && st_ff.core_interrupt_control[IC_CHG_EN] && ce &&
      !(wr && sel == SEL_CORE_INTERRUPT_CONTROL) |=> wake_req || !sleep_mode;
  endproperty
  a_wake: assert property (p_wake)
    else $error("change did not wake");

  // Hardware sets reach the sticky status as well as the flag
  property p_sts_set;
    ce && chg |=> st_ff.irq_sts[ST_CHG];
  endproperty
  a_sts_set: assert property (p_sts_set)
    else $error("mismatch did not set status");

  property p_ext_sts;
    ce && ext_edge |=> st_ff.core_interrupt_control[IC_EXT_FLAG] && st_ff.irq_sts[ST_EXT];
  endproperty
  a_ext_sts: assert property (p_ext_sts)
    else $error("pin 0 edge did not set flag and status");

  // The edge not selected must leave the flag alone
  property p_edge_quiet;
    ce ##1 ce && !(st_ff.option[OPT_EDGE_SEL] ?
      ($rose(pin_in[0])) : ($fell(pin_in[0]))) &&
      !st_ff.core_interrupt_control[IC_EXT_FLAG] && !(wr && sel == SEL_CORE_INTERRUPT_CONTROL)
      |=> !st_ff.core_interrupt_control[IC_EXT_FLAG];
  endproperty
  a_edge_quiet: assert property (p_edge_quiet)
    else $error("wrong edge set the pin 0 flag");

  property p_chg_irq;
    ce && chg && st_ff.core_interrupt_control[IC_GLOBAL_EN] && st_ff.core_interrupt_control[IC_CHG_EN] &&
      !(wr && sel == SEL_CORE_INTERRUPT_CONTROL) |=> core_irq;
  endproperty
  a_chg_irq: assert property (p_chg_irq)
    else $error("enabled change gave no core request");

  // Masked output; a mask write in the same cycle may hide the event
  property p_irq_msk;
    ce && chg && st_ff.irq_msk[ST_CHG] && !(wr && sel == SEL_MSK)
      |=> irq;
  endproperty
  a_irq_msk: assert property (p_irq_msk)
    else $error("unmasked status gave no irq");

  property p_opt_write;
    ce && wr && sel == SEL_OPTION |=> st_ff.option == $past(pwdata[7:0]);
  endproperty
  a_opt_write: assert property (p_opt_write)
    else $error("option write lost");

  property p_dir_write;
    ce && wr && sel == SEL_DIR |=> st_ff.dir == $past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");

  property p_flag_write;
    ce && wr && sel == SEL_CORE_INTERRUPT_CONTROL && !chg && !ext_edge
      |=> st_ff.core_interrupt_control == $past(pwdata[7:0]);
  endproperty
  a_flag_write: assert property (p_flag_write)
    else $error("control write lost");

  // Unmapped words must not disturb any register
  property p_unmapped;
    ce && acc && sel == SEL_NONE |=> st_ff.option == $past(st_ff.option) &&
      st_ff.dir == $past(st_ff.dir) && st_ff.out_latch == $past(st_ff.out_latch) &&
      st_ff.irq_msk == $past(st_ff.irq_msk);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access changed a register");

  // Reference moves only on port access; polling is why changes hide
  property p_ref_hold;
    ce && !port_acc |=> $stable(st_ff.ref_val);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference moved without port access");

  // Read clears only what it returned
  property p_sts_clear;
    ce && rd && sel == SEL_STS && !chg && !ext_edge
      |=> (st_ff.irq_sts & $past(st_ff.prdata[1:0])) == 2'h0;
  endproperty
  a_sts_clear: assert property (p_sts_clear)
    else $error("status read did not clear");

  property p_prdata_hold;
    !setup |=> $stable(st_ff.prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data moved outside setup");

  // Clock enable low freezes every bit of state
  property p_frozen;
    !ce |=> $stable(st_ff);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while clock enable low");

  c_chg: cover property (ce && chg ##1 st_ff.core_interrupt_control[IC_CHG_FLAG]);
  c_thaw: cover property (!ce ##1 ce && chg);
  c_ext: cover property (ce && ext_edge ##1 irq);
  c_wake: cover property (wake_req);
  c_sts_clear: cover property (rd && sel == SEL_STS ##1 st_ff.irq_sts == 2'h0);

endmodule : upper_io_port_change_int
`default_nettype wire

// ===== tb/upio_pin_model.sv
// Keypad side of the port: drives floated lines, models pull-ups
`timescale 1ns/100ps
`default_nettype none
module upio_pin_model (
  input  wire logic       sys_clk,    // Core clock
  input  wire logic [7:0] pin_out,    // Device drive levels
  input  wire logic [7:0] pin_oe_n,   // Low while device drives
  input  wire logic [7:0] pullup_en,  // Device weak pull-ups
  input  wire logic [7:0] key_en,     // Keypad drives the line
  input  wire logic [7:0] key_val,    // Keypad level
  output logic      [7:0] pin_lvl     // Resolved wire level
);
  logic [7:0] last_ff;  // Last level, for lines nobody holds
  // Resolve each line; an undriven one shows the inverse of its last level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pin_oe_n[i])
        pin_lvl[i] = pin_out[i];   // Device drives from latch
      else if (key_en[i])
        pin_lvl[i] = key_val[i];   // Keypad drives a floated line
      else if (pullup_en[i])
        pin_lvl[i] = 1'b1;         // Weak pull-up holds it high
      else
        pin_lvl[i] = ~last_ff[i];  // No keeper, so the level wanders
    end
  end
  // Remember the wire so a floating line cannot look stable
  always_ff @(posedge sys_clk)
    last_ff <= pin_lvl;
endmodule : upio_pin_model
`default_nettype wire

// ===== tb/upper_io_port_change_int_tb.sv
// Self-checking bench for the upper I/O port with change interrupt
`timescale 1ns/100ps
`default_nettype none
module upper_io_port_change_int_tb;
  import upio_pkg::*;
  logic              sys_clk, rst, ce, psel, penable, pwrite, sleep_mode;
  logic [ADDR_W-1:0] paddr;       // APB byte address
  logic [31:0]       pwdata, prdata, rdv;
  logic              pready, pslverr, err, wake_req, core_irq, irq;
  logic [7:0]        pin_in, pin_out, pin_oe_n, pullup_en, key_en, key_val;
  int                bad_count, n_compared;
  upper_io_port_change_int i_upper_io_port_change_int (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .core_irq(core_irq), .irq(irq));
  upio_pin_model i_upio_pin_model (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .key_en(key_en), .key_val(key_val),
    .pin_lvl(pin_in));
  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ADDR_W'({idx, 2'b00});
    pwdata  <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      bad_count++;   // Slave never answered
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let n edges pass, then look at settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    {rst, ce, psel, penable, pwrite, sleep_mode} = 6'b110000;
    {paddr, pwdata, key_en, key_val} = {ADDR_W'(0), 32'h0, 8'hff, 8'h00};
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    chk("oe_n rst", 8'hff, pin_oe_n);
    chk("pullup rst", 8'h00, pullup_en);
    apb(1'b0, IDX_OPTION, 8'h0); chk("option rst", 8'hff, rdv);
    apb(1'b0, IDX_DIR, 8'h0); chk("dir rst", 8'hff, rdv);
    apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("ctrl rst", 8'h00, rdv);
    apb(1'b0, 8'h8f, 8'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rdv);
    // Pull-ups on, upper half driven by the latch, lower half left to pull-ups
    apb(1'b1, IDX_OPTION, 8'h7f); apb(1'b1, IDX_DIR, 8'h0f); apb(1'b1, IDX_PORT, 8'ha5);
    key_en <= 8'h00;
    cyc(1);
    chk("pullup", 8'h0f, pullup_en);
    chk("oe_n", 8'h0f, pin_oe_n);
    chk("pin_out", 8'ha5, pin_out);
    apb(1'b0, IDX_PORT, 8'h0); chk("port lvl", 8'haf, rdv);
    // Change interrupt: all inputs, keypad holds lines, reference 0
    key_en <= 8'hff;
    apb(1'b1, IDX_DIR, 8'hff); apb(1'b1, IDX_OPTION, 8'hff);
    apb(1'b0, IDX_PORT, 8'h0); apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h0); apb(1'b0, IDX_IRQ_STS, 8'h0);
    key_val <= 8'h20;
    cyc(3);
    chk("irq masked", 1'b0, irq);
    // No port polling from here until the handler refreshes the reference
    apb(1'b1, IDX_IRQ_MSK, 8'h03); cyc(1); chk("irq", 1'b1, irq);
    apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("chg flag", 1'b1, rdv[IC_CHG_FLAG]);
    apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h89); cyc(1); chk("core_irq", 1'b1, core_irq);
    @(posedge sys_clk);
    sleep_mode <= 1'b1;
    apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h08); cyc(1);
    chk("wake", 2'b10, {wake_req, core_irq});
    @(posedge sys_clk);
    sleep_mode <= 1'b0;
    apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h00); apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0);
    chk("flag held", 1'b1, rdv[IC_CHG_FLAG]);
    apb(1'b0, IDX_PORT, 8'h0); apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h00); apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0);
    chk("flag clr", 1'b0, rdv[IC_CHG_FLAG]);
    apb(1'b0, IDX_IRQ_STS, 8'h0); chk("sts", 1'b1, rdv[ST_CHG]);
    apb(1'b0, IDX_IRQ_STS, 8'h0); chk("sts clr", 2'b00, rdv[1:0]);
    // Clock enable low: a new mismatch waits until it returns
    @(posedge sys_clk);
    ce      <= 1'b0;
    key_val <= 8'h60;
    cyc(3);
    chk("frozen irq", 1'b0, irq);
    @(posedge sys_clk);
    ce <= 1'b1;
    cyc(1);
    chk("thawed irq", 1'b1, irq);
    @(posedge sys_clk);
    key_val <= 8'h20;
    apb(1'b0, IDX_IRQ_STS, 8'h0); chk("ce sts", 1'b1, rdv[ST_CHG]);
    // Output pin 4 toggles and lower pins move: neither may flag a change
    apb(1'b1, IDX_DIR, 8'hef); apb(1'b1, IDX_PORT, 8'h30); apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h00);
    key_val <= 8'h2e;
    cyc(3);
    apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("excluded", 1'b0, rdv[IC_CHG_FLAG]);
    // Pin 0 edge interrupt, both edge selections
    apb(1'b1, IDX_DIR, 8'hff);
    for (int es = 1; es >= 0; es--)
    begin
      key_val[0] <= ~es[0];
      apb(1'b1, IDX_OPTION, {1'b1, es[0], 6'h3f}); cyc(2); apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h0);
      key_val[0] <= es[0];
      cyc(2);
      apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("ext act", 1'b1, rdv[IC_EXT_FLAG]);
      apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h92);
      cyc(2);
      chk("ext irq", 1'b1, core_irq);
      apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("ext flag", 8'h92, rdv);
      // Flag cleared, then the edge that is not selected
      apb(1'b1, IDX_CORE_INTERRUPT_CONTROL, 8'h10);
      key_val[0] <= ~es[0];
      cyc(2);
      apb(1'b0, IDX_CORE_INTERRUPT_CONTROL, 8'h0); chk("ext idle", 1'b0, rdv[IC_EXT_FLAG]);
    end
    end_of_test();
  end
endmodule : upper_io_port_change_int_tb
`default_nettype wire
